// ===== rtl/tas_pkg.sv
// ****************************************************************
// Shared constants of the touch converter scan control.
// ****************************************************************
package tas_pkg;

  // Register pages and the control register offset.
  localparam logic [1:0] PAGE_DATA = 2'h0;
  localparam logic [1:0] PAGE_CTRL = 2'h1;
  localparam logic [5:0] CTRL_ADDR = 6'h00;

  // Control register field positions.
  localparam int PEN_BIT = 15;
  localparam int IDLE_BIT = 14;
  localparam int SCAN_HI = 13;
  localparam int SCAN_LO = 10;
  localparam int RES_HI = 9;
  localparam int RES_LO = 8;

  // Reset values of the control fields and of the result registers.
  localparam logic [3:0] SCAN_RST = 4'h0;
  localparam logic [1:0] WIDTH_RST = 2'h0;
  localparam logic [15:0] RESULT_RST = 16'h0000;

  // Scan selection codes.
  localparam logic [3:0] SCAN_NONE = 4'h0;
  localparam logic [3:0] SCAN_XY = 4'h1;
  localparam logic [3:0] SCAN_XYZ = 4'h2;
  localparam logic [3:0] SCAN_X = 4'h3;
  localparam logic [3:0] SCAN_Y = 4'h4;
  localparam logic [3:0] SCAN_Z = 4'h5;
  localparam logic [3:0] SCAN_CELL = 4'h6;
  localparam logic [3:0] SCAN_SPARE2 = 4'h7;
  localparam logic [3:0] SCAN_SPARE1 = 4'h8;
  localparam logic [3:0] SCAN_AUTO = 4'h9;
  localparam logic [3:0] SCAN_THERM1 = 4'hA;
  localparam logic [3:0] SCAN_PORT = 4'hB;
  localparam logic [3:0] SCAN_THERM2 = 4'hC;
  localparam logic [3:0] SCAN_DRV_X = 4'hD;
  localparam logic [3:0] SCAN_DRV_YX = 4'hE;
  localparam logic [3:0] SCAN_DRV_YX2 = 4'hF;

  // Conversion width codes.
  localparam logic [1:0] RES_12 = 2'h0;
  localparam logic [1:0] RES_8 = 2'h1;
  localparam logic [1:0] RES_10 = 2'h2;
  localparam logic [1:0] RES_12B = 2'h3;

  // Channel indices, which are also the result offsets on the data page.
  localparam int NUM_CH = 9;
  localparam logic [3:0] CH_X = 4'h0;
  localparam logic [3:0] CH_Y = 4'h1;
  localparam logic [3:0] CH_ZA = 4'h2;
  localparam logic [3:0] CH_ZB = 4'h3;
  localparam logic [3:0] CH_CELL = 4'h4;
  localparam logic [3:0] CH_SP1 = 4'h5;
  localparam logic [3:0] CH_SP2 = 4'h6;
  localparam logic [3:0] CH_TH1 = 4'h7;
  localparam logic [3:0] CH_TH2 = 4'h8;

  // Sequencer states, one-hot.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_START = 3'b010,
    ST_WAIT = 3'b100
  } tas_state_t;

endpackage

// ===== rtl/tas_result_file.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// Read-only result registers, one per channel.
// ****************************************************************
module tas_result_file #(
  parameter int NUM = 9,
  parameter int DW = 12
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic wrEn,
  input wire logic [3:0] wrIdx,
  input wire logic [DW-1:0] wrData,
  input wire logic [3:0] rdIdx,
  output logic [15:0] rdData
);

  // Stored results, right-justified values only.
  logic [DW-1:0] res_ff [NUM];

  // Results clear on reset and take each finished conversion.
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < NUM; i++) begin
        res_ff[i] <= tas_pkg::RESULT_RST[DW-1:0];
      end
    end else if (ce && wrEn && (int'(wrIdx) < NUM)) begin
      res_ff[wrIdx] <= wrData;
    end
  end

  // Upper bits always read as zero; unknown slots read as zero.
  always_comb begin
    rdData = 16'h0000;
    if (int'(rdIdx) < NUM) begin
      rdData = {{(16 - DW){1'b0}}, res_ff[rdIdx]};
    end
  end

endmodule
`default_nettype wire

// ===== rtl/tas_scan_control.sv
`timescale 1ns/1ns
`default_nettype none
module tas_scan_control #(
  parameter int DW = 12
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [1:0] regPage,
  input wire logic [5:0] regAddr,
  input wire logic regWrEn,
  input wire logic [15:0] regWrData,
  input wire logic regRdEn,
  output logic [15:0] regRdData,
  output logic regRdValid,
  input wire logic penDownPin,
  input wire logic [3:0] autoSelect,
  output logic convStart,
  output logic [3:0] convChannel,
  output logic [1:0] convResolution,
  output logic convPowerDown,
  input wire logic convDone,
  input wire logic [DW-1:0] convData,
  output logic drvXPos,
  output logic drvXNeg,
  output logic drvYPos,
  output logic drvYNeg
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // One-hot channel bit.
  function automatic logic [8:0] bitOf(input logic [3:0] ch);
    bitOf = 9'h001 << ch;
  endfunction

  // Channels that one pass of a scan code converts.
  function automatic logic [8:0] chanMask(input logic [3:0] code,
                                          input logic [3:0] sel);
    chanMask = 9'h000;
    case (code)
      tas_pkg::SCAN_XY: chanMask = bitOf(tas_pkg::CH_X) | bitOf(tas_pkg::CH_Y);
      tas_pkg::SCAN_XYZ: begin
        chanMask = bitOf(tas_pkg::CH_X) | bitOf(tas_pkg::CH_Y)
                 | bitOf(tas_pkg::CH_ZA) | bitOf(tas_pkg::CH_ZB);
      end
      tas_pkg::SCAN_X: chanMask = bitOf(tas_pkg::CH_X);
      tas_pkg::SCAN_Y: chanMask = bitOf(tas_pkg::CH_Y);
      tas_pkg::SCAN_Z: chanMask = bitOf(tas_pkg::CH_ZA) | bitOf(tas_pkg::CH_ZB);
      tas_pkg::SCAN_CELL: chanMask = bitOf(tas_pkg::CH_CELL);
      tas_pkg::SCAN_SPARE2: chanMask = bitOf(tas_pkg::CH_SP2);
      tas_pkg::SCAN_THERM1: chanMask = bitOf(tas_pkg::CH_TH1);
      tas_pkg::SCAN_THERM2: chanMask = bitOf(tas_pkg::CH_TH2);
      tas_pkg::SCAN_SPARE1: chanMask = bitOf(tas_pkg::CH_SP1);
      tas_pkg::SCAN_AUTO: chanMask = {sel, 5'h00};
      tas_pkg::SCAN_PORT: begin
        chanMask = bitOf(tas_pkg::CH_CELL) | bitOf(tas_pkg::CH_SP1)
                 | bitOf(tas_pkg::CH_SP2);
      end
      default: chanMask = 9'h000;
    endcase
  endfunction

  // Lowest pending channel index.
  function automatic logic [3:0] lowest(input logic [8:0] m);
    lowest = 4'h0;
    for (int i = 8; i >= 0; i--) begin
      if (m[i]) begin
        lowest = 4'(i);
      end
    end
  endfunction

  // Panel codes wait for the pen under device sequencing.
  function automatic logic isPanel(input logic [3:0] code);
    isPanel = (code >= tas_pkg::SCAN_XY) && (code <= tas_pkg::SCAN_Z);
  endfunction

  // Keeps only the bits that the chosen width produces.
  function automatic logic [DW-1:0] fitWidth(input logic [DW-1:0] d,
                                             input logic [1:0] w);
    fitWidth = d;
    if (w == tas_pkg::RES_8) begin
      fitWidth = d & DW'(12'h0FF);
    end else if (w == tas_pkg::RES_10) begin
      fitWidth = d & DW'(12'h3FF);
    end
  endfunction

  // ****************************************************************
  // Pen input synchroniser
  // ****************************************************************
  logic penMeta_ff; // First stage, read only by the second.
  logic penSync_ff; // Pen level in the clock domain.
  logic penPrev_ff; // Previous level for edge detection.

  // Two stages bring the pen pin into the clock domain.
  always_ff @(posedge clk) begin
    if (srst) begin
      penMeta_ff <= 1'b0;
      penSync_ff <= 1'b0;
      penPrev_ff <= 1'b0;
    end else if (ce) begin
      penMeta_ff <= penDownPin;
      penSync_ff <= penMeta_ff;
      penPrev_ff <= penSync_ff;
    end
  end

  // ****************************************************************
  // Control register
  // ****************************************************************
  logic seqByDevice_ff; // Device runs panel sequencing when set.
  logic stop_ff; // Converter stopped and powered down.
  logic [3:0] scan_ff; // Scan selection field.
  logic [1:0] width_ff; // Conversion width field.
  logic ctrlWr; // Write strobe to the control register.
  logic [3:0] newScan; // Scan code being written.

  assign ctrlWr = ce && regWrEn && (regPage == tas_pkg::PAGE_CTRL)
                  && (regAddr == tas_pkg::CTRL_ADDR);
  assign newScan = regWrData[tas_pkg::SCAN_HI:tas_pkg::SCAN_LO];
  // Writable control fields; result page writes are ignored.
  always_ff @(posedge clk) begin
    if (srst) begin
      seqByDevice_ff <= 1'b0;
      stop_ff <= 1'b0;
      scan_ff <= tas_pkg::SCAN_RST;
      width_ff <= tas_pkg::WIDTH_RST;
    end else if (ctrlWr) begin
      seqByDevice_ff <= regWrData[tas_pkg::PEN_BIT];
      stop_ff <= regWrData[tas_pkg::IDLE_BIT];
      scan_ff <= newScan;
      width_ff <= regWrData[tas_pkg::RES_HI:tas_pkg::RES_LO];
    end
  end

  // ****************************************************************
  // Scan sequencer
  // ****************************************************************
  tas_pkg::tas_state_t state_ff; // Sequencer state.
  logic [8:0] pend_ff; // Channels left in this pass.
  logic [3:0] curChan_ff; // Channel being converted.
  logic hostTrig; // Write that starts a scan now.
  logic penTrig; // Pen touch that starts a panel scan.
  logic [8:0] wrMask; // Channels of the code being written.
  logic [8:0] reMask; // Channels of the held code.
  logic loopOn; // Held code repeats its pass.
  logic doneNow; // Current conversion finishes.

  assign wrMask = chanMask(newScan, autoSelect);
  assign reMask = chanMask(scan_ff, autoSelect);
  // Host sequencing starts on the write; device sequencing of panel codes waits for a touch.
  assign hostTrig = ctrlWr && !regWrData[tas_pkg::IDLE_BIT]
                    && (!regWrData[tas_pkg::PEN_BIT] || !isPanel(newScan));
  assign penTrig = ce && seqByDevice_ff && !stop_ff && penSync_ff && !penPrev_ff
                   && isPanel(scan_ff) && (state_ff == tas_pkg::ST_IDLE);
  // Panel loops need the pen; the auto scan runs until stopped.
  assign loopOn = ((scan_ff == tas_pkg::SCAN_XY || scan_ff == tas_pkg::SCAN_XYZ)
                   && penSync_ff) || (scan_ff == tas_pkg::SCAN_AUTO);
  assign doneNow = ce && (state_ff == tas_pkg::ST_WAIT) && convDone;
  // Walks the channel list of the selected code, one conversion at a time.
  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= tas_pkg::ST_IDLE;
      pend_ff <= 9'h000;
      curChan_ff <= 4'h0;
    end else if (ctrlWr && regWrData[tas_pkg::IDLE_BIT]) begin
      // A stop abandons the scan at once.
      state_ff <= tas_pkg::ST_IDLE;
      pend_ff <= 9'h000;
    end else if (hostTrig) begin
      // A new code restarts the sequence, even mid-scan.
      if (wrMask != 9'h000) begin
        curChan_ff <= lowest(wrMask);
        pend_ff <= wrMask & ~bitOf(lowest(wrMask));
        state_ff <= tas_pkg::ST_START;
      end else begin
        pend_ff <= 9'h000;
        state_ff <= tas_pkg::ST_IDLE;
      end
    end else if (penTrig && reMask != 9'h000) begin
      curChan_ff <= lowest(reMask);
      pend_ff <= reMask & ~bitOf(lowest(reMask));
      state_ff <= tas_pkg::ST_START;
    end else if (ce) begin
      case (state_ff)
        tas_pkg::ST_IDLE: begin
          state_ff <= tas_pkg::ST_IDLE;
        end
        tas_pkg::ST_START: begin
          state_ff <= tas_pkg::ST_WAIT;
        end
        tas_pkg::ST_WAIT: begin
          if (convDone) begin
            if (pend_ff != 9'h000) begin
              // Next channel of this pass.
              curChan_ff <= lowest(pend_ff);
              pend_ff <= pend_ff & ~bitOf(lowest(pend_ff));
              state_ff <= tas_pkg::ST_START;
            end else if (loopOn && reMask != 9'h000) begin
              // Repeat the pass.
              curChan_ff <= lowest(reMask);
              pend_ff <= reMask & ~bitOf(lowest(reMask));
              state_ff <= tas_pkg::ST_START;
            end else begin
              state_ff <= tas_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          state_ff <= tas_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Converter and panel driver outputs
  // ****************************************************************
  assign convStart = (state_ff == tas_pkg::ST_START);
  assign convChannel = curChan_ff;
  assign convPowerDown = stop_ff;
  logic [1:0] convRes_ff; // Width code sent to the converter.

  // Width field folded so both 12-bit codes look alike to the converter.
  always_ff @(posedge clk) begin
    if (srst) begin
      convRes_ff <= tas_pkg::RES_12;
    end else if (ce) begin
      if (width_ff == tas_pkg::RES_12B) begin
        convRes_ff <= tas_pkg::RES_12;
      end else begin
        convRes_ff <= width_ff;
      end
    end
  end
  assign convResolution = convRes_ff;

  logic drvXPos_ff; // Horizontal plus driver.
  logic drvXNeg_ff; // Horizontal minus driver.
  logic drvYPos_ff; // Vertical plus driver.
  // Direct driver codes hold the drivers on while selected and not stopped.
  always_ff @(posedge clk) begin
    if (srst) begin
      drvXPos_ff <= 1'b0;
      drvXNeg_ff <= 1'b0;
      drvYPos_ff <= 1'b0;
    end else if (ce) begin
      drvXPos_ff <= !stop_ff && (scan_ff == tas_pkg::SCAN_DRV_X);
      drvXNeg_ff <= !stop_ff && (scan_ff >= tas_pkg::SCAN_DRV_X);
      drvYPos_ff <= !stop_ff && (scan_ff >= tas_pkg::SCAN_DRV_YX);
    end
  end
  assign drvXPos = drvXPos_ff;
  assign drvXNeg = drvXNeg_ff;
  assign drvYPos = drvYPos_ff;
  assign drvYNeg = 1'b0;

  // ****************************************************************
  // Result storage and register reads
  // ****************************************************************
  logic [15:0] resRd; // Result selected by the read address.
  tas_result_file #(
    .NUM(tas_pkg::NUM_CH),
    .DW(DW)
  ) u_results (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .wrEn(doneNow),
    .wrIdx(curChan_ff),
    .wrData(fitWidth(convData, width_ff)),
    .rdIdx(regAddr[3:0]),
    .rdData(resRd)
  );

  logic [15:0] rdData_ff; // Read answer.
  logic rdValid_ff; // Read answer strobe.
  // Reads answer one cycle later; unmapped addresses read zero.
  always_ff @(posedge clk) begin
    if (srst) begin
      rdData_ff <= 16'h0000;
      rdValid_ff <= 1'b0;
    end else if (ce) begin
      rdValid_ff <= regRdEn;
      if (!regRdEn) begin
        rdData_ff <= rdData_ff;
      end else if (regPage == tas_pkg::PAGE_CTRL && regAddr == tas_pkg::CTRL_ADDR) begin
        rdData_ff <= {penSync_ff, state_ff == tas_pkg::ST_IDLE,
                      scan_ff, width_ff, 8'h00};
      end else if (regPage == tas_pkg::PAGE_DATA && regAddr[5:4] == 2'h0) begin
        rdData_ff <= resRd;
      end else begin
        rdData_ff <= 16'h0000;
      end
    end
  end
  assign regRdData = rdData_ff;
  assign regRdValid = rdValid_ff;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  chk_result_write: assert property (
    @(posedge clk) disable iff (srst)
    doneNow |=> (u_results.res_ff[$past(curChan_ff)] == $past(fitWidth(convData, width_ff))))
    else $error("Result not stored in its channel register.");
  chk_result_upper: assert property (
    @(posedge clk) disable iff (srst)
    (ce && regRdEn && regPage == tas_pkg::PAGE_DATA) |=> (regRdData[15:12] == 4'h0))
    else $error("Result upper bits not zero.");
  chk_pen_read: assert property (
    @(posedge clk) disable iff (srst)
    (ce && regRdEn && regPage == tas_pkg::PAGE_CTRL && regAddr == tas_pkg::CTRL_ADDR)
    |=> (regRdData[15] == $past(penSync_ff)))
    else $error("Pen bit does not follow pen.");
  chk_idle_read: assert property (
    @(posedge clk) disable iff (srst)
    (ce && regRdEn && regPage == tas_pkg::PAGE_CTRL && regAddr == tas_pkg::CTRL_ADDR)
    |=> (regRdData[14] == ($past(state_ff) == tas_pkg::ST_IDLE)))
    else $error("Idle bit wrong.");
  chk_stop_abort: assert property (
    @(posedge clk) disable iff (srst)
    (ctrlWr && regWrData[14]) |=> (state_ff == tas_pkg::ST_IDLE && convPowerDown))
    else $error("Stop did not abort and power down.");
  chk_loop_end: assert property (
    @(posedge clk) disable iff (srst)
    (doneNow && pend_ff == 9'h000 && !ctrlWr && !penSync_ff
     && scan_ff != tas_pkg::SCAN_AUTO) |=> (state_ff == tas_pkg::ST_IDLE))
    else $error("Pass did not end when pen lifted.");
  chk_width_fold: assert property (
    @(posedge clk) disable iff (srst)
    (ce && width_ff == tas_pkg::RES_12B) |=> (convResolution == tas_pkg::RES_12))
    else $error("Width code three not treated as 12 bits.");
  chk_start_pulse: assert property (
    @(posedge clk) disable iff (srst)
    (convStart && ce && !ctrlWr) |=> (!convStart && state_ff == tas_pkg::ST_WAIT))
    else $error("Start pulse longer than one cycle.");
  chk_driver_x: assert property (
    @(posedge clk) disable iff (srst)
    (ce && scan_ff == tas_pkg::SCAN_DRV_X && !stop_ff) |=> (drvXPos && drvXNeg && !drvYPos))
    else $error("Horizontal drivers not enabled.");

endmodule
`default_nettype wire

// ===== testbench/tas_conv_model.sv
`timescale 1ns/1ns
`default_nettype none
// ********
// Converter model that answers each start pulse.
// ********
module tas_conv_model #(
  parameter int DW = 12
) (
  input wire logic clk,
  input wire logic convStart,
  input wire logic convPowerDown,
  input wire logic [1:0] convResolution,
  input wire logic slow,
  input wire logic [DW-1:0] nextData,
  output logic convDone,
  output logic [DW-1:0] convData
);
  // Cycles left in the conversion under way, zero when idle.
  int left;
  // Keeps narrow results right-aligned in the word.
  logic [DW-1:0] mask;

  // Picks the result mask from the width the converter is told.
  always_comb begin
    case (convResolution)
      2'h1: mask = DW'(12'h0FF);
      2'h2: mask = DW'(12'h3FF);
      default: mask = '1;
    endcase
  end

  // Starts from a quiet state so the first edge sees known lines.
  initial begin
    left = 0;
    convDone = 1'b0;
    convData = '0;
  end

  // Counts each conversion down; the data lines toggle outside results.
  always @(posedge clk) begin
    convDone <= 1'b0;
    convData <= ~convData;
    if (convPowerDown) begin
      left <= 0;
    end else if (convStart) begin
      left <= slow ? 40 : 2;
    end else if (left == 1) begin
      left <= 0;
      convDone <= 1'b1;
      convData <= nextData & mask;
    end else if (left > 1) begin
      left <= left - 1;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/test_touch_adc_scan_control.sv
`timescale 1ns/1ns
`default_nettype none
module test_touch_adc_scan_control;
  // ********
  // Signals and bookkeeping.
  // ********
  logic clk, srst, ce, regWrEn, regRdEn, penDownPin, slow;
  logic [1:0] regPage, convResolution, wExp;
  logic [5:0] regAddr;
  logic [15:0] regWrData, regRdData;
  logic regRdValid, convStart, convPowerDown, convDone;
  logic [3:0] autoSelect, convChannel, curCh;
  logic [11:0] convData, nextData;
  logic drvXPos, drvXNeg, drvYPos, drvYNeg;
  int error_cnt = 0;
  int total_checks = 0;
  int startCnt = 0;
  int doneCnt = 0;
  logic [15:0] rdQ[$];
  logic [3:0] chQ[$];
  logic [11:0] expRes[9];
  logic [31:0] seed = 32'hE290;
  logic [3:0] codeT[9] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hA, 4'hC, 4'hB};
  int nT[9] = '{1, 1, 2, 1, 1, 1, 1, 1, 3};
  logic [11:0] chT[9] = '{12'h000, 12'h001, 12'h032, 12'h004, 12'h006, 12'h005,
                          12'h007, 12'h008, 12'h654};

  tas_scan_control DUT (.clk, .srst, .ce, .regPage, .regAddr, .regWrEn, .regWrData,
    .regRdEn, .regRdData, .regRdValid, .penDownPin, .autoSelect, .convStart,
    .convChannel, .convResolution, .convPowerDown, .convDone, .convData, .drvXPos,
    .drvXNeg, .drvYPos, .drvYNeg);
  tas_conv_model conv (.clk, .convStart, .convPowerDown, .convResolution, .slow,
    .nextData, .convDone, .convData);

  // ********
  // Helpers.
  // ********
  function automatic logic [11:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[11:0];
  endfunction

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [1:0] pg, input logic [5:0] ad, input logic [15:0] d);
    @(posedge clk);
    #1;
    regPage = pg;
    regAddr = ad;
    regWrData = d;
    regWrEn = 1'b1;
    cyc(1);
    regWrEn = 1'b0;
  endtask

  // Notes the expected answer, then issues the read strobe.
  task automatic rd(input logic [1:0] pg, input logic [5:0] ad, input logic [15:0] e);
    rdQ.push_back(e);
    @(posedge clk);
    #1;
    regPage = pg;
    regAddr = ad;
    regRdEn = 1'b1;
    cyc(1);
    regRdEn = 1'b0;
  endtask

  // Waits, under a bound, for the start or done count to reach n.
  task automatic waitFor(input bit st, input int n);
    int i;
    for (i = 0; i < 3000; i++) begin
      if ((st ? startCnt : doneCnt) >= n) break;
      @(posedge clk);
    end
    if (i == 3000) begin
      error_cnt++;
      $display("unexpected count exp %0d got timeout", n);
    end
    #1;
  endtask

  task automatic tdone(input string nm);
    $display("test %s ended", nm);
  endtask

  task automatic end_of_test();
    if (rdQ.size() > 0 || chQ.size() > 0) error_cnt++;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ********
  // Clock, watchdog and result monitor.
  // ********
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Cuts a hang short well past the expected run length.
  initial begin
    #400000;
    error_cnt++;
    $display("unexpected run time exp done got timeout");
    end_of_test();
  end

  // Takes the oldest note whenever the design shows a result.
  always @(negedge clk) begin
    if (regRdValid) begin
      if (rdQ.size() > 0) chk("regRdData", rdQ.pop_front(), regRdData);
      else chk("regRdValid", 16'h0000, 16'h0001);
    end
    if (convStart) begin
      startCnt++;
      nextData = rnd();
      curCh = (chQ.size() > 0) ? chQ.pop_front() : 4'hF;
      chk("convChannel", {12'h000, curCh}, {12'h000, convChannel});
    end
    if (convDone) begin
      doneCnt++;
      if (curCh < 4'h9) expRes[curCh] = convData;
      chk("convResolution", {14'h0000, wExp}, {14'h0000, convResolution});
    end
  end

  // ********
  // Main sequence.
  // ********
  initial begin
    int base;
    int n;
    logic [1:0] w;
    logic [3:0] ch;
    {srst, ce, regWrEn, regRdEn, penDownPin, slow} = 6'h30;
    {regPage, regAddr, regWrData, autoSelect, nextData, wExp} = '0;
    repeat (2) @(posedge clk);
    #1;
    srst = 1'b0;
    rd(2'h1, 6'h00, 16'h4000);
    for (int c = 0; c < 9; c++) rd(2'h0, 6'(c), 16'h0000);
    tdone("reset");
    for (int i = 0; i < 9; i++) begin
      base = doneCnt;
      slow = ^rnd();
      w = 2'(i);
      wExp = (w == 2'h3) ? 2'h0 : w;
      for (int k = 0; k < nT[i]; k++) chQ.push_back(4'(chT[i] >> (4 * k)));
      wr(2'h1, 6'h00, {2'h0, codeT[i], w, 8'h00});
      waitFor(1'b0, base + nT[i]);
      cyc(3);
      rd(2'h1, 6'h00, {2'h1, codeT[i], w, 8'h00});
      for (int k = 0; k < nT[i]; k++) begin
        ch = 4'(chT[i] >> (4 * k));
        rd(2'h0, 6'(ch), {4'h0, expRes[ch]});
      end
    end
    tdone("single");
    wExp = 2'h0;
    slow = 1'b1;
    penDownPin = 1'b1;
    for (int m = 1; m <= 2; m++) begin
      base = doneCnt;
      for (int k = 0; k < 4 * m; k++) chQ.push_back(4'(k % (2 * m)));
      wr(2'h1, 6'h00, {2'h0, 4'(m), 10'h000});
      cyc(10);
      rd(2'h1, 6'h00, {2'h2, 4'(m), 10'h000});
      waitFor(1'b0, base + 4 * m - 1);
      penDownPin = 1'b0;
      waitFor(1'b0, base + 4 * m);
      cyc(8);
      rd(2'h1, 6'h00, {2'h1, 4'(m), 10'h000});
      penDownPin = 1'b1;
      cyc(5);
    end
    tdone("loop");
    base = startCnt;
    chQ.push_back(4'h0);
    chQ.push_back(4'h1);
    wr(2'h1, 6'h00, 16'h0800);
    waitFor(1'b1, base + 2);
    wr(2'h1, 6'h00, 16'h4000);
    cyc(5);
    chk("convPowerDown", 16'h0001, {15'h0000, convPowerDown});
    rd(2'h1, 6'h00, 16'hC000);
    rd(2'h0, 6'h01, {4'h0, expRes[1]});
    tdone("stop");
    slow = 1'b0;
    penDownPin = 1'b0;
    cyc(5);
    base = doneCnt;
    wr(2'h1, 6'h00, 16'h8C00);
    cyc(20);
    chQ.push_back(4'h0);
    penDownPin = 1'b1;
    waitFor(1'b0, base + 1);
    penDownPin = 1'b0;
    cyc(3);
    rd(2'h0, 6'h00, {4'h0, expRes[0]});
    tdone("device mode");
    autoSelect = 4'(rnd()) | 4'h2;
    slow = 1'b1;
    base = startCnt;
    for (int k = 0; k < 4; k++) if (autoSelect[k]) chQ.push_back(4'(5 + k));
    chQ.push_back(chQ[0]);
    n = chQ.size();
    wr(2'h1, 6'h00, 16'h2400);
    waitFor(1'b1, base + n);
    wr(2'h1, 6'h00, 16'h4000);
    cyc(3);
    for (int k = 0; k < 4; k++) begin
      if (autoSelect[k]) rd(2'h0, 6'(5 + k), {4'h0, expRes[5 + k]});
    end
    tdone("auto scan");
    for (int d = 13; d <= 15; d++) begin
      wr(2'h1, 6'h00, {2'h0, 4'(d), 10'h000});
      cyc(2);
      chk("drivers", (d == 13) ? 16'h000C : 16'h0006,
          {12'h000, drvXPos, drvXNeg, drvYPos, drvYNeg});
    end
    wr(2'h1, 6'h00, 16'h0000);
    cyc(2);
    chk("drivers", 16'h0000, {12'h000, drvXPos, drvXNeg, drvYPos, drvYNeg});
    tdone("drivers");
    wr(2'h0, 6'h00, 16'hFFFF);
    wr(2'h1, 6'h05, 16'hFFFF);
    ce = 1'b0;
    wr(2'h1, 6'h00, 16'h0C00);
    ce = 1'b1;
    rd(2'h1, 6'h00, 16'h4000);
    rd(2'h0, 6'h00, {4'h0, expRes[0]});
    rd(2'h1, 6'h05, 16'h0000);
    rd(2'h0, 6'h09, 16'h0000);
    cyc(3);
    tdone("refused");
    end_of_test();
  end
endmodule
`default_nettype wire
